// File: src/pdgc_pkg.sv
/*
 * Package for the PCM DMA pacing, interrupt and data/strobe receive block:
 * register offsets, field positions, reset values and carrier structs.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package pdgc_pkg;

	// Register byte offsets
	localparam logic [7:0] PDGC_OFS_DMA = 8'h00;
	localparam logic [7:0] PDGC_OFS_IEN = 8'h04;
	localparam logic [7:0] PDGC_OFS_IST = 8'h08;
	localparam logic [7:0] PDGC_OFS_GRAY = 8'h0C;
	localparam logic [7:0] PDGC_OFS_CTRL = 8'h10;

	// Threshold field positions
	localparam int PDGC_TXPAN_LSB = 24;
	localparam int PDGC_RXPAN_LSB = 16;
	localparam int PDGC_TXREQ_LSB = 8;
	localparam int PDGC_RXREQ_LSB = 0;
	localparam int PDGC_THR_W = 7;

	// Threshold reset values
	localparam logic [6:0] PDGC_TXPAN_RST = 7'h10;
	localparam logic [6:0] PDGC_RXPAN_RST = 7'h30;
	localparam logic [6:0] PDGC_TXREQ_RST = 7'h30;
	localparam logic [6:0] PDGC_RXREQ_RST = 7'h20;

	// Interrupt cause bit positions
	localparam int PDGC_IRQ_RX_ERROR_IRQ = 3;
	localparam int PDGC_IRQ_TX_ERROR_IRQ = 2;
	localparam int PDGC_IRQ_RXR = 1;
	localparam int PDGC_IRQ_TXW = 0;

	// Gray register field positions
	localparam int PDGC_G_EN = 0;
	localparam int PDGC_G_CLR = 1;
	localparam int PDGC_G_FLUSH = 2;
	localparam int PDGC_G_LVL_LSB = 4;
	localparam int PDGC_G_FLD_LSB = 10;
	localparam int PDGC_G_FIFO_LSB = 16;

	// Interrupt threshold fields in the extra control register
	localparam int PDGC_TX_IRQ_THRESHOLD_LSB = 0;
	localparam int PDGC_RX_IRQ_THRESHOLD_LSB = 8;
	localparam logic [6:0] PDGC_TX_IRQ_THRESHOLD_RST = 7'h00;
	localparam logic [6:0] PDGC_RX_IRQ_THRESHOLD_RST = 7'h00;

	// Gray word size
	localparam logic [5:0] PDGC_WORD_BITS = 6'h20;

	// One DMA control group
	typedef struct packed {
		logic req;
		logic panic;
	} pdgc_dma_t;

	// Wishbone request bundle
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} pdgc_wb_req_t;

endpackage

// File: src/pdgc_top.sv
/*
 * PCM DMA pacing, interrupt latching and gray (data/strobe) receiver.
 * Assumes FIFO levels and error pulses come from logic on clk_i; the
 * serial data and strobe pins are asynchronous and slow compared to clk_i.
 */
// Operation
// - Two DMA groups, transmit and receive, each with request and panic.
// - Transmit panic while transmit level below threshold bits 30:24.
// - Receive panic while receive level above threshold bits 22:16.
// - Transmit request while transmit level below threshold bits 14:8.
// - Receive request while receive level above threshold bits 6:0.
// - Enable bit 3 permits receive error interrupt.
// - Enable bit 2 permits transmit error interrupt.
// - Bit 1 enables interrupt while receive level at or above threshold.
// - Bit 0 enables interrupt while transmit level below threshold.
// - A status bit is latched per cause, same positions as enables.
// - Writing one clears a status bit; writing zero leaves it.
// - Gray enable bit 0 selects data/strobe reception on data and strobe.
// - Received bits counted in bits 9:4; full 32-bit word goes to FIFO.
// - Flush bit 2 writes partial buffer from bit zero, zero padded.
// - Flush bit always reads zero, also while a flush is pending.
// - Each flush records number of valid bits in bits 15:10.
// - Clear bit 1 resets gray logic and discards buffer until cleared.
// - Receive FIFO word count readable in bits 21:16.
`timescale 1ns/10ps
module pdgc_top
	import pdgc_pkg::*;
#(
	parameter int LVL_W = 7
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// FIFO levels and events
	input wire logic [LVL_W-1:0] tx_fifo_level_i,
	input wire logic [LVL_W-1:0] rx_fifo_level_i,
	input wire logic tx_fifo_err_i,
	input wire logic rx_fifo_err_i,
	// DMA control groups
	output logic tx_dma_transfer_request_o,
	output logic tx_dma_panic_o,
	output logic rx_dma_transfer_request_o,
	output logic rx_dma_panic_o,
	// Interrupt
	output logic irq_o,
	// Gray serial pins
	input wire logic gray_data_i,
	input wire logic gray_strobe_i,
	// Gray word output to receive FIFO
	output logic [31:0] gray_word_o,
	output logic gray_word_valid_o
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	pdgc_wb_req_t req;
	logic [3:0] sel;
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] wmask;
	wire logic acc = req.cyc & req.stb & ~ack_q;
	wire logic wr = req.cyc & req.stb & ack_q & req.we; // Lands with ack
	wire logic hit_dma = req.adr == PDGC_OFS_DMA;
	wire logic hit_ien = req.adr == PDGC_OFS_IEN;
	wire logic hit_ist = req.adr == PDGC_OFS_IST;
	wire logic hit_gray = req.adr == PDGC_OFS_GRAY;
	wire logic hit_ctrl = req.adr == PDGC_OFS_CTRL;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
		sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
	assign sel = req.sel;

	// Byte lanes expanded to a bit mask
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_mask
			assign wmask[gb*8 +: 8] = {8{sel[gb]}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [31:0] dma_q;
	logic [3:0] ien_q;
	logic [31:0] ctrl_q;
	logic [31:0] dma_d;
	logic [31:0] ctrl_d;
	logic [31:0] dma_rst;
	logic [31:0] ctrl_rst;

	always_comb begin
		dma_rst = 32'h0000_0000;
		dma_rst[PDGC_TXPAN_LSB +: PDGC_THR_W] = PDGC_TXPAN_RST;
		dma_rst[PDGC_RXPAN_LSB +: PDGC_THR_W] = PDGC_RXPAN_RST;
		dma_rst[PDGC_TXREQ_LSB +: PDGC_THR_W] = PDGC_TXREQ_RST;
		dma_rst[PDGC_RXREQ_LSB +: PDGC_THR_W] = PDGC_RXREQ_RST;
		ctrl_rst = 32'h0000_0000;
		ctrl_rst[PDGC_TX_IRQ_THRESHOLD_LSB +: PDGC_THR_W] = PDGC_TX_IRQ_THRESHOLD_RST;
		ctrl_rst[PDGC_RX_IRQ_THRESHOLD_LSB +: PDGC_THR_W] = PDGC_RX_IRQ_THRESHOLD_RST;
	end

	// Only the 7-bit fields are kept; reserved bits stay zero
	assign dma_d = ((dma_q & ~wmask) | (req.dat & wmask)) & 32'h7F7F_7F7F;
	assign ctrl_d = ((ctrl_q & ~wmask) | (req.dat & wmask)) & 32'h0000_7F7F;

	// Writes are not blocked while running; software must hold off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dma_q <= dma_rst;
			ien_q <= 4'h0;
			ctrl_q <= ctrl_rst;
		end else begin
			if (wr && hit_dma) begin
				dma_q <= dma_d;
			end
			if (wr && hit_ien && sel[0]) begin
				ien_q <= req.dat[3:0];
			end
			if (wr && hit_ctrl) begin
				ctrl_q <= ctrl_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// DMA pacing
	wire logic [6:0] tx_pan_thr = dma_q[PDGC_TXPAN_LSB +: PDGC_THR_W];
	wire logic [6:0] rx_pan_thr = dma_q[PDGC_RXPAN_LSB +: PDGC_THR_W];
	wire logic [6:0] tx_req_thr = dma_q[PDGC_TXREQ_LSB +: PDGC_THR_W];
	wire logic [6:0] rx_req_thr = dma_q[PDGC_RXREQ_LSB +: PDGC_THR_W];
	wire logic [6:0] tx_lvl = 7'(tx_fifo_level_i);
	wire logic [6:0] rx_lvl = 7'(rx_fifo_level_i);
	pdgc_dma_t tx_dma_d;
	pdgc_dma_t rx_dma_d;

	assign tx_dma_d.panic = tx_lvl < tx_pan_thr;
	assign rx_dma_d.panic = rx_lvl > rx_pan_thr;
	assign tx_dma_d.req = tx_lvl < tx_req_thr;
	assign rx_dma_d.req = rx_lvl > rx_req_thr;

	// Registered so the DMA sees glitch-free levels; one cycle of lag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_dma_transfer_request_o <= 1'b0;
			tx_dma_panic_o <= 1'b0;
			rx_dma_transfer_request_o <= 1'b0;
			rx_dma_panic_o <= 1'b0;
		end else begin
			tx_dma_transfer_request_o <= tx_dma_d.req;
			tx_dma_panic_o <= tx_dma_d.panic;
			rx_dma_transfer_request_o <= rx_dma_d.req;
			rx_dma_panic_o <= rx_dma_d.panic;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status
	logic [3:0] ist_q;
	logic [3:0] ist_set;
	logic [3:0] ist_clr;
	wire logic [6:0] tx_irq_threshold = ctrl_q[PDGC_TX_IRQ_THRESHOLD_LSB +: PDGC_THR_W];
	wire logic [6:0] rx_irq_threshold = ctrl_q[PDGC_RX_IRQ_THRESHOLD_LSB +: PDGC_THR_W];

	assign ist_set[PDGC_IRQ_RX_ERROR_IRQ] = rx_fifo_err_i
		& ien_q[PDGC_IRQ_RX_ERROR_IRQ];
	assign ist_set[PDGC_IRQ_TX_ERROR_IRQ] = tx_fifo_err_i
		& ien_q[PDGC_IRQ_TX_ERROR_IRQ];
	assign ist_set[PDGC_IRQ_RXR] = (rx_lvl >= rx_irq_threshold)
		& ien_q[PDGC_IRQ_RXR];
	assign ist_set[PDGC_IRQ_TXW] = (tx_lvl < tx_irq_threshold)
		& ien_q[PDGC_IRQ_TXW];
	assign ist_clr = (wr && hit_ist && sel[0]) ? req.dat[3:0] : 4'h0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_q <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			ist_q <= (ist_q & ~ist_clr) | ist_set;
			irq_o <= |(ist_q & ien_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gray pin synchronisers
	logic [1:0] dat_sync_q;
	logic [1:0] stb_sync_q;
	logic dat_prev_q;
	logic stb_prev_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_sync_q <= 2'b00;
			stb_sync_q <= 2'b00;
			dat_prev_q <= 1'b0;
			stb_prev_q <= 1'b0;
		end else begin
			dat_sync_q <= {dat_sync_q[0], gray_data_i};
			stb_sync_q <= {stb_sync_q[0], gray_strobe_i};
			dat_prev_q <= dat_sync_q[1];
			stb_prev_q <= stb_sync_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gray receiver
	// Data/strobe: exactly one of the two lines toggles per bit cell.
	logic g_en_q;
	logic g_clr_q;
	logic flush_req_q;
	logic [31:0] buf_q;
	logic [5:0] lvl_q;
	logic [5:0] flushed_q;
	logic [5:0] fifo_cnt_q;
	wire logic [5:0] fifo_cnt_d;
	wire logic bit_evt = g_en_q & ~g_clr_q &
		((dat_sync_q[1] ^ dat_prev_q) | (stb_sync_q[1] ^ stb_prev_q));
	wire logic [31:0] buf_d = buf_q | ({31'h0, dat_sync_q[1]} << lvl_q[4:0]);
	wire logic [5:0] lvl_inc = lvl_q + 6'h01;
	wire logic word_full = bit_evt && (lvl_inc == PDGC_WORD_BITS);
	wire logic do_flush = flush_req_q & ~bit_evt;
	wire logic gray_wr = wr & hit_gray & sel[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			g_en_q <= 1'b0;
			g_clr_q <= 1'b0;
		end else if (gray_wr) begin
			g_en_q <= req.dat[PDGC_G_EN];
			g_clr_q <= req.dat[PDGC_G_CLR];
		end
	end

	// Flush waits for an idle bit cell so no bit is lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush_req_q <= 1'b0;
		end else if (gray_wr && req.dat[PDGC_G_FLUSH]) begin
			flush_req_q <= 1'b1;
		end else if (do_flush || g_clr_q) begin
			flush_req_q <= 1'b0;
		end
	end

	// Bit packing, word push and flush; clear dumps the buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_q <= 32'h0000_0000;
			lvl_q <= 6'h00;
			flushed_q <= 6'h00;
			gray_word_o <= 32'h0000_0000;
			gray_word_valid_o <= 1'b0;
		end else begin
			gray_word_valid_o <= 1'b0;
			if (g_clr_q) begin
				buf_q <= 32'h0000_0000;
				lvl_q <= 6'h00;
				flushed_q <= 6'h00;
			end else if (word_full) begin
				gray_word_o <= buf_d;
				gray_word_valid_o <= 1'b1;
				buf_q <= 32'h0000_0000;
				lvl_q <= 6'h00;
			end else if (bit_evt) begin
				buf_q <= buf_d;
				lvl_q <= lvl_inc;
			end else if (do_flush) begin
				gray_word_o <= buf_q;
				gray_word_valid_o <= lvl_q != 6'h00;
				flushed_q <= lvl_q;
				buf_q <= 32'h0000_0000;
				lvl_q <= 6'h00;
			end
		end
	end

	// Word count of the receive FIFO, saturated to its field
	assign fifo_cnt_d = (rx_lvl > 7'h3F) ? 6'h3F : rx_lvl[5:0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_cnt_q <= 6'h00;
		end else begin
			fifo_cnt_q <= fifo_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux and ack
	logic [31:0] gray_rd;
	logic [31:0] rd_d;

	always_comb begin
		gray_rd = 32'h0000_0000;
		gray_rd[PDGC_G_EN] = g_en_q;
		gray_rd[PDGC_G_CLR] = g_clr_q;
		gray_rd[PDGC_G_FLUSH] = 1'b0;
		gray_rd[PDGC_G_LVL_LSB +: 6] = lvl_q;
		gray_rd[PDGC_G_FLD_LSB +: 6] = flushed_q;
		gray_rd[PDGC_G_FIFO_LSB +: 6] = fifo_cnt_q;
	end

	assign rd_d = hit_dma ? dma_q :
		hit_ien ? {28'h0, ien_q} :
		hit_ist ? {28'h0, ist_q} :
		hit_gray ? gray_rd :
		hit_ctrl ? ctrl_q : 32'h0000_0000;

	// One wait state; unmapped addresses ack and read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			rdat_q <= acc ? rd_d : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

endmodule // pdgc_top

// File: testbench/pdgc_ds_src.sv
/*
 * Data/strobe serial source, one bit per 160 ns link period.
 * Assumes the receiver samples both lines with its own clock.
 */
`timescale 1ns/10ps
module pdgc_ds_src (
	// Serial lines
	output logic data_o,
	output logic strobe_o
);
	// Lines keep their levels between bursts, as real lines do
	initial begin
		data_o = 1'b0;
		strobe_o = 1'b0;
	end
	// Exactly one line toggles per bit, lowest bit first
	task automatic send(input logic [31:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			#160;
			if (bits[i] !== data_o)
				data_o <= bits[i];
			else
				strobe_o <= ~strobe_o;
		end
	endtask
endmodule // pdgc_ds_src

// File: testbench/pdgc_top_chk.sv
/*
 * Port-level checker for pdgc_top: DMA compares, bus answer, interrupts.
 * Assumes byte lanes are always all enabled on register writes.
 */
`timescale 1ns/10ps
module pdgc_top_chk
	import pdgc_pkg::*;
#(
	parameter int LVL_W = 7
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Levels, events and results
	input wire logic [LVL_W-1:0] tx_fifo_level_i,
	input wire logic [LVL_W-1:0] rx_fifo_level_i,
	input wire logic rx_fifo_err_i,
	input wire logic tx_dma_transfer_request_o,
	input wire logic tx_dma_panic_o,
	input wire logic rx_dma_transfer_request_o,
	input wire logic rx_dma_panic_o,
	input wire logic irq_o,
	input wire logic gray_word_valid_o
);
	logic [31:0] thr_q;
	logic [3:0] ien_q;
	wire wr_ack = wb_ack_o && wb_we_i;
	wire [6:0] txpan = thr_q[30:24];
	wire [6:0] rxpan = thr_q[22:16];
	wire [6:0] txreq = thr_q[14:8];
	wire [6:0] rxreq = thr_q[6:0];
	////////////////////////////////////////////////////////////////////////
	// Shadow of written settings, taken at the acknowledging edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thr_q <= {1'b0, PDGC_TXPAN_RST, 1'b0, PDGC_RXPAN_RST,
				1'b0, PDGC_TXREQ_RST, 1'b0, PDGC_RXREQ_RST};
			ien_q <= 4'h0;
		end else if (wr_ack && wb_adr_i == PDGC_OFS_DMA) begin
			thr_q <= wb_dat_i;
		end else if (wr_ack && wb_adr_i == PDGC_OFS_IEN) begin
			ien_q <= wb_dat_i[3:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Outputs lag their compares by one cycle, so look one edge back
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_TXPAN: assert property (!$past(rst_i) |-> tx_dma_panic_o ==
		($past(tx_fifo_level_i) < $past(txpan))) else $error("tx panic wrong");
	AST_RXPAN: assert property (!$past(rst_i) |-> rx_dma_panic_o ==
		($past(rx_fifo_level_i) > $past(rxpan))) else $error("rx panic wrong");
	AST_TXREQ: assert property (!$past(rst_i) |->
		tx_dma_transfer_request_o == ($past(tx_fifo_level_i) < $past(txreq)))
		else $error("tx request wrong");
	AST_RXREQ: assert property (!$past(rst_i) |->
		rx_dma_transfer_request_o == ($past(rx_fifo_level_i) > $past(rxreq)))
		else $error("rx request wrong");
	AST_IRQ_ERR: assert property (
		rx_fifo_err_i && ien_q[3] |-> ##2 irq_o)
		else $error("rx error irq missing");
	AST_IRQ_OFF: assert property (!$past(rst_i) && $past(ien_q) == 4'h0
		|-> !irq_o) else $error("irq without enable");
	AST_ACK_LAT: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	AST_FLUSH_RD: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == PDGC_OFS_GRAY |-> !wb_dat_o[PDGC_G_FLUSH])
		else $error("flush bit reads one");
	AST_WORD_ONE: assert property (
		gray_word_valid_o |=> !gray_word_valid_o)
		else $error("word pulse long");
endmodule // pdgc_top_chk
bind pdgc_top pdgc_top_chk #(.LVL_W(LVL_W)) i_pdgc_top_chk (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .tx_fifo_level_i, .rx_fifo_level_i, .rx_fifo_err_i,
	.tx_dma_transfer_request_o, .tx_dma_panic_o, .rx_dma_transfer_request_o,
	.rx_dma_panic_o, .irq_o, .gray_word_valid_o);

// File: testbench/tb_top.sv
/*
 * Self-checking bench for pdgc_top: registers, DMA, interrupts, gray.
 * Assumes the package, design, source model and checker are compiled.
 */
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top
	import pdgc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pdgc_wb_req_t m = '0;
	logic [6:0] txl = 7'h00;
	logic [6:0] rxl = 7'h00;
	logic txe = 1'b0;
	logic rxe = 1'b0;
	logic [31:0] rd;
	logic [31:0] lastw = 32'h0000_0000;
	wire [31:0] rdat;
	wire [31:0] gw;
	wire ack, txr, txp, rx_read_irq, rxp, irq, gv, gd, gs;
	int checks = 0;
	int n_mismatch = 0;
	int nw = 0;
	pdgc_top #(.LVL_W(7)) i_pdgc_top (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(m.cyc), .wb_stb_i(m.stb), .wb_we_i(m.we), .wb_sel_i(m.sel),
		.wb_adr_i(m.adr), .wb_dat_i(m.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.tx_fifo_level_i(txl), .rx_fifo_level_i(rxl), .tx_fifo_err_i(txe),
		.rx_fifo_err_i(rxe), .tx_dma_transfer_request_o(txr),
		.tx_dma_panic_o(txp), .rx_dma_transfer_request_o(rx_read_irq),
		.rx_dma_panic_o(rxp), .irq_o(irq), .gray_data_i(gd),
		.gray_strobe_i(gs), .gray_word_o(gw), .gray_word_valid_o(gv));
	pdgc_ds_src i_pdgc_ds_src (.data_o(gd), .strobe_o(gs));
	////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and a word monitor that cannot miss a pulse
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		#100us;
		n_mismatch++;
		test_done();
	end
	always @(posedge clk) begin
		if (gv === 1'b1) begin
			lastw <= gw;
			nw <= nw + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// One classic cycle; waits for ack however late it comes
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		m <= '{1'b1, 1'b1, w, 4'hF, a, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		m <= '0;
		@(posedge clk);
	endtask
	task automatic pulse(input bit tx);
		if (tx) txe <= 1'b1;
		else rxe <= 1'b1;
		@(posedge clk);
		txe <= 1'b0;
		rxe <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic dma(input logic [6:0] t, input logic [6:0] r,
		input logic [3:0] e);
		txl <= t;
		rxl <= r;
		repeat (3) @(posedge clk);
		`CHK("dma", e, {txp, txr, rxp, rx_read_irq})
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		wb(1'b0, PDGC_OFS_DMA, 32'h0000_0000);
		`CHK("dma_thr", 32'h1030_3020, rd)
		for (int i = 1; i < 8; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0000_0000);
			`CHK("reg_rst", 32'h0000_0000, rd)
		end
	endtask
	task automatic t_dma();
		dma(7'h0F, 7'h31, 4'hF);
		dma(7'h10, 7'h30, 4'h5);
		dma(7'h30, 7'h20, 4'h0);
		wb(1'b1, PDGC_OFS_DMA, 32'h0505_0505);
		dma(7'h04, 7'h06, 4'hF);
		dma(7'h05, 7'h05, 4'h0);
	endtask
	task automatic t_irq();
		wb(1'b1, PDGC_OFS_CTRL, 32'h0000_7F00);
		wb(1'b1, PDGC_OFS_IEN, 32'h0000_000C);
		pulse(1'b0);
		wb(1'b0, PDGC_OFS_IST, 32'h0000_0000);
		`CHK("ist_rx", 32'h0000_0008, rd)
		`CHK("irq", 1'b1, irq)
		wb(1'b1, PDGC_OFS_IST, 32'h0000_0007);
		wb(1'b0, PDGC_OFS_IST, 32'h0000_0000);
		`CHK("ist_keep", 32'h0000_0008, rd)
		wb(1'b1, PDGC_OFS_IST, 32'h0000_0008);
		pulse(1'b1);
		wb(1'b0, PDGC_OFS_IST, 32'h0000_0000);
		`CHK("ist_tx", 32'h0000_0004, rd)
		wb(1'b1, PDGC_OFS_IST, 32'h0000_0004);
		wb(1'b1, PDGC_OFS_CTRL, 32'h0000_0506);
		wb(1'b1, PDGC_OFS_IEN, 32'h0000_0003);
		repeat (3) @(posedge clk);
		wb(1'b0, PDGC_OFS_IST, 32'h0000_0000);
		`CHK("ist_lvl", 32'h0000_0003, rd)
		txl <= 7'h06;
		rxl <= 7'h04;
		wb(1'b1, PDGC_OFS_IST, 32'h0000_0003);
		repeat (3) @(posedge clk);
		wb(1'b0, PDGC_OFS_IST, 32'h0000_0000);
		`CHK("ist_clr", 32'h0000_0000, rd)
		`CHK("irq_clr", 1'b0, irq)
	endtask
	task automatic t_gray();
		wb(1'b1, PDGC_OFS_GRAY, 32'h0000_0001);
		i_pdgc_ds_src.send(32'hA5C3_0F96, 32);
		repeat (10) @(posedge clk);
		`CHK("word", 32'hA5C3_0F96, lastw)
		wb(1'b0, PDGC_OFS_GRAY, 32'h0000_0000);
		`CHK("gray", 32'h0004_0001, rd)
		i_pdgc_ds_src.send(32'h0000_0016, 5);
		repeat (8) @(posedge clk);
		wb(1'b0, PDGC_OFS_GRAY, 32'h0000_0000);
		`CHK("gray_lvl", 32'h0004_0051, rd)
		wb(1'b1, PDGC_OFS_GRAY, 32'h0000_0005);
		repeat (10) @(posedge clk);
		`CHK("flush", 32'h0000_0016, lastw)
		`CHK("nw", 2, nw)
		wb(1'b0, PDGC_OFS_GRAY, 32'h0000_0000);
		`CHK("gray_fl", 32'h0004_1401, rd)
		i_pdgc_ds_src.send(32'h0000_0007, 3);
		repeat (8) @(posedge clk);
		wb(1'b1, PDGC_OFS_GRAY, 32'h0000_0003);
		wb(1'b0, PDGC_OFS_GRAY, 32'h0000_0000);
		`CHK("gray_clr", 7'h01, {rd[9:4], rd[1]})
		wb(1'b1, PDGC_OFS_GRAY, 32'h0000_0001);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Verdict and main sequence
	task automatic test_done();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_dma();
		t_irq();
		t_gray();
		test_done();
	end
endmodule // tb_top
